// [rtl/pfi_param_bank.sv]
// Parameter bank: user labels, fault injection path and terminal communication preset.
//
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module pfi_param_bank #(
  parameter int ADDR_W = 12
) (
  input  wire logic                core_clk,
  input  wire logic                rst,
  input  wire logic [ADDR_W-1:0]   paddr,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                realFaultValid,
  input  wire logic [7:0]          realFaultCode,
  input  wire logic                driveReset,
  input  wire logic                panelMenuWrite,
  input  wire logic [15:0]         panelMenuData,
  output logic                     faultAlarmOutput,
  output logic                     retryEnable,
  output logic      [7:0]          displayCode,
  output pfi_pkg::pfi_hist_t       histRecord,
  output pfi_pkg::pfi_nvm_t        nvmStore,
  output pfi_pkg::pfi_comm_t       commSettings,
  output logic                     presetDone
);

  // Below 7 bits the comm mirror words at 0x040 and 0x044 are out of reach; above 12 the decode would alias.
  if (ADDR_W < 7 || ADDR_W > 12) begin
    $error("ADDR_W must lie between 7 and 12");
  end

  localparam pfi_pkg::pfi_state_t ST_INIT = '{
    label1:  pfi_pkg::LABEL_INIT,
    label2:  pfi_pkg::LABEL_INIT,
    extSel:  pfi_pkg::EXT_SEL_INIT,
    retryEn: 1'b1,
    comm:    pfi_pkg::COMM_INIT,
    default: '0
  };

  pfi_pkg::pfi_state_t s_r;
  pfi_pkg::pfi_state_t s_nxt;
  logic [11:0]         addr12;
  logic                setupPhase;
  logic                accessPhase;
  logic                reqErr;
  logic [31:0]         rdData;
  logic [31:0]         statusWord;
  logic                loadPreset;

  function automatic logic faultCodeOk(input logic [31:0] v);
    logic ok;
    case (v[7:0])
      8'h10, 8'h11, 8'h12, 8'h20, 8'h21, 8'h22, 8'h30, 8'h31,
      8'h40, 8'h52, 8'h60, 8'h61, 8'h70, 8'h80, 8'h81, 8'h90,
      8'h91, 8'hB0, 8'hB1, 8'hB2, 8'hC0, 8'hC4, 8'hC5, 8'hC7,
      8'hC9, 8'hD0, 8'hE6, 8'hF5: ok = 1'b1;
      default: ok = 1'b0;
    endcase
    return ok && (v[31:8] == 24'h00_0000);
  endfunction

  function automatic logic isParam(input logic [11:0] a);
    return (a == pfi_pkg::ADDR_LABEL1) || (a == pfi_pkg::ADDR_LABEL2) ||
           (a == pfi_pkg::ADDR_FAULT) || (a == pfi_pkg::ADDR_PRESET);
  endfunction

  function automatic logic [15:0] commWord(input pfi_pkg::pfi_comm_t c,
                                           input logic [11:0] a);
    logic [3:0] idx;
    logic [11:0] off;
    off = a - pfi_pkg::ADDR_COMM_BASE;
    idx = off[5:2];
    return c[(9 - idx) * 16 +: 16];
  endfunction

  assign addr12      = 12'(paddr);
  assign setupPhase  = psel && !penable;
  assign accessPhase = psel && penable && s_r.pready;

  always_comb begin
    statusWord = '0;
    statusWord[pfi_pkg::STAT_ACTIVE_BIT] = s_r.faultActive;
    statusWord[pfi_pkg::STAT_INJ_BIT] = s_r.injected;
    statusWord[pfi_pkg::STAT_RETRY_BIT] = s_r.retryEn;
    statusWord[pfi_pkg::STAT_CODE_LSB +: 8] = s_r.faultCode;
    statusWord[pfi_pkg::STAT_DISP_LSB +: 8] = s_r.dispCode;
    statusWord[pfi_pkg::STAT_HIST_LSB +: 8] = s_r.histNewest;
  end

  // Request checks are made in the setup cycle so that the answer can leave a flip-flop.
  always_comb begin
    reqErr = 1'b0;
    rdData = '0;
    case (addr12)
      pfi_pkg::ADDR_LABEL1: begin
        rdData = {16'h0000, s_r.label1};
        reqErr = pwrite && (pwdata > 32'(pfi_pkg::LABEL_MAX));
      end
      pfi_pkg::ADDR_LABEL2: begin
        rdData = {16'h0000, s_r.label2};
        reqErr = pwrite && (pwdata > 32'(pfi_pkg::LABEL_MAX));
      end
      pfi_pkg::ADDR_FAULT: begin
        rdData = 32'(pfi_pkg::NO_ACTION);
        reqErr = pwrite && !faultCodeOk(pwdata) &&
                 (pwdata != 32'(pfi_pkg::NO_ACTION));
      end
      pfi_pkg::ADDR_PRESET: begin
        rdData = 32'(pfi_pkg::NO_ACTION);
        reqErr = pwrite && (pwdata != 32'(pfi_pkg::PRESET_CODE)) &&
                 (pwdata != 32'(pfi_pkg::NO_ACTION));
      end
      pfi_pkg::ADDR_CTRL: begin
        rdData = {16'h0000, s_r.extSel};
      end
      pfi_pkg::ADDR_STATUS: begin
        rdData = statusWord;
        reqErr = pwrite;
      end
      default: begin
        if (addr12 >= pfi_pkg::ADDR_COMM_BASE && addr12 <= pfi_pkg::ADDR_COMM_LAST &&
            addr12[1:0] == 2'b00) begin
          rdData = {16'h0000, commWord(s_r.comm, addr12)};
          reqErr = pwrite;
        end else begin
          reqErr = 1'b1;
        end
      end
    endcase
    if ((s_r.extSel != 16'h0000) && isParam(addr12)) begin
      reqErr = 1'b1;
    end
  end

  always_comb begin
    s_nxt = s_r;
    loadPreset = 1'b0;
    s_nxt.pready = 1'b0;
    s_nxt.pslverr = 1'b0;
    s_nxt.presetDone = 1'b0;
    s_nxt.hist.valid = 1'b0;
    s_nxt.nvm.write = 1'b0;
    if (driveReset) begin
      s_nxt.faultActive = 1'b0;
      s_nxt.injected = 1'b0;
      s_nxt.alarm = 1'b0;
      s_nxt.retryEn = 1'b1;
      s_nxt.dispCode = s_r.histNewest;
    end
    // A real fault in the reset cycle wins over the clear; one after injection is dropped.
    if (realFaultValid && (!s_r.faultActive || driveReset)) begin
      s_nxt.faultActive = 1'b1;
      s_nxt.injected = 1'b0;
      s_nxt.alarm = 1'b1;
      s_nxt.retryEn = 1'b1;
      s_nxt.faultCode = realFaultCode;
      s_nxt.histNewest = realFaultCode;
      s_nxt.dispCode = realFaultCode;
      s_nxt.hist.valid = 1'b1;
      s_nxt.hist.code = realFaultCode;
    end
    if (setupPhase) begin
      s_nxt.pready = 1'b1;
      s_nxt.pslverr = reqErr;
      s_nxt.prdata = reqErr ? 32'h0000_0000 : rdData;
    end
    // Writes land only at the access edge; labels are never gated by run state or mode.
    if (accessPhase && pwrite && !s_r.pslverr) begin
      case (addr12)
        pfi_pkg::ADDR_LABEL1: begin
          s_nxt.label1 = pwdata[15:0];
          s_nxt.nvm.write = 1'b1;
          s_nxt.nvm.addr = 1'b0;
          s_nxt.nvm.data = pwdata[15:0];
        end
        pfi_pkg::ADDR_LABEL2: begin
          s_nxt.label2 = pwdata[15:0];
          s_nxt.nvm.write = 1'b1;
          s_nxt.nvm.addr = 1'b1;
          s_nxt.nvm.data = pwdata[15:0];
        end
        pfi_pkg::ADDR_FAULT: begin
          // Nothing here reaches the store port, so injected codes never persist.
          if (faultCodeOk(pwdata) && !s_r.faultActive && !realFaultValid) begin
            s_nxt.faultActive = 1'b1;
            s_nxt.injected = 1'b1;
            s_nxt.alarm = 1'b1;
            s_nxt.retryEn = 1'b0;
            s_nxt.faultCode = pwdata[7:0];
            s_nxt.dispCode = pwdata[7:0];
          end
        end
        pfi_pkg::ADDR_PRESET: begin
          if (pwdata == 32'(pfi_pkg::PRESET_CODE)) begin
            loadPreset = 1'b1;
          end
        end
        pfi_pkg::ADDR_CTRL: begin
          s_nxt.extSel = pwdata[15:0];
        end
        default: begin
        end
      endcase
    end
    if (panelMenuWrite && panelMenuData == pfi_pkg::PANEL_PRESET_CODE) begin
      loadPreset = 1'b1;
    end
    // The new settings only act after the operator resets the drive.
    if (loadPreset) begin
      s_nxt.comm = pfi_pkg::COMM_PRESET;
      s_nxt.presetDone = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_r <= ST_INIT;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata           = s_r.prdata;
  assign pready           = s_r.pready;
  assign pslverr          = s_r.pslverr;
  assign faultAlarmOutput = s_r.alarm;
  assign retryEnable      = s_r.retryEn;
  assign displayCode      = s_r.dispCode;
  assign histRecord       = s_r.hist;
  assign nvmStore         = s_r.nvm;
  assign commSettings     = s_r.comm;
  assign presetDone       = s_r.presetDone;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  chk_label_range: assert property (
    s_r.label1 <= pfi_pkg::LABEL_MAX && s_r.label2 <= pfi_pkg::LABEL_MAX)
    else $error("user label beyond 9999");

  chk_label_store: assert property (
    accessPhase && pwrite && !pslverr && addr12 == pfi_pkg::ADDR_LABEL2
    |=> nvmStore.write && nvmStore.addr && nvmStore.data == $past(pwdata[15:0]))
    else $error("label write not sent to store");

  chk_ext_gate: assert property (
    setupPhase && s_r.extSel != 16'h0000 && isParam(addr12)
    |=> pready && pslverr && prdata == 32'h0000_0000)
    else $error("parameter reachable while display select is set");

  chk_inject_trip: assert property (
    accessPhase && pwrite && !pslverr && addr12 == pfi_pkg::ADDR_FAULT &&
    pwdata != 32'(pfi_pkg::NO_ACTION) && !s_r.faultActive && !realFaultValid
    |=> faultAlarmOutput && displayCode == $past(pwdata[7:0]) && !histRecord.valid)
    else $error("valid injection did not trip the drive");

  chk_bad_code: assert property (
    setupPhase && pwrite && addr12 == pfi_pkg::ADDR_FAULT && !faultCodeOk(pwdata) &&
    pwdata != 32'(pfi_pkg::NO_ACTION)
    |=> pslverr ##1 ($stable(s_r.faultActive) || $past(realFaultValid || driveReset)))
    else $error("unlisted injection code accepted");

  chk_fault_read: assert property (
    accessPhase && !pwrite && !pslverr && addr12 == pfi_pkg::ADDR_FAULT
    |-> prdata == 32'(pfi_pkg::NO_ACTION))
    else $error("fault trigger read not 9999");

  chk_inject_store: assert property (
    accessPhase && pwrite && addr12 == pfi_pkg::ADDR_FAULT |=> !nvmStore.write)
    else $error("injection value sent to store");

  chk_reset_restore: assert property (
    s_r.injected && driveReset && !realFaultValid
    |=> !faultAlarmOutput && displayCode == $past(s_r.histNewest) && !histRecord.valid)
    else $error("drive reset did not restore history");

  chk_inject_busy: assert property (
    accessPhase && pwrite && addr12 == pfi_pkg::ADDR_FAULT && s_r.faultActive && !driveReset
    |=> $stable(displayCode) && $stable(s_r.faultCode))
    else $error("injection taken while a fault was active");

  chk_no_retry: assert property (
    s_r.injected |-> !retryEnable && faultAlarmOutput)
    else $error("retry enabled for an injected fault");

  chk_late_fault: assert property (
    s_r.injected && realFaultValid && !driveReset
    |=> !histRecord.valid && $stable(displayCode))
    else $error("real fault after injection changed display");

  chk_preset_load: assert property (
    accessPhase && pwrite && !pslverr && addr12 == pfi_pkg::ADDR_PRESET &&
    pwdata == 32'(pfi_pkg::PRESET_CODE)
    |=> presetDone && commSettings == pfi_pkg::COMM_PRESET ##1 !presetDone)
    else $error("preset did not load terminal settings");

  chk_preset_read: assert property (
    accessPhase && !pwrite && !pslverr && addr12 == pfi_pkg::ADDR_PRESET
    |-> prdata == 32'(pfi_pkg::NO_ACTION))
    else $error("preset trigger read not 9999");

  chk_panel_preset: assert property (
    panelMenuWrite && panelMenuData == pfi_pkg::PANEL_PRESET_CODE
    |=> presetDone && commSettings == pfi_pkg::COMM_PRESET)
    else $error("panel preset did not load settings");

  chk_reset_state: assert property (disable iff (1'b0)
    rst |=> !pready && !pslverr && !faultAlarmOutput && retryEnable && !presetDone &&
    displayCode == 8'h00 && s_r.label1 == pfi_pkg::LABEL_INIT &&
    commSettings == pfi_pkg::COMM_INIT)
    else $error("reset state wrong");

  chk_bus_answer: assert property (
    setupPhase |=> pready)
    else $error("setup cycle not answered");

  chk_bus_pulse: assert property (
    pready |=> !pready)
    else $error("ready held past one cycle");

  chk_label_accept: assert property (
    accessPhase && pwrite && !pslverr && addr12 == pfi_pkg::ADDR_LABEL1
    |=> s_r.label1 == $past(pwdata[15:0]))
    else $error("label write not taken");

  chk_label1_store: assert property (
    accessPhase && pwrite && !pslverr && addr12 == pfi_pkg::ADDR_LABEL1
    |=> nvmStore.write && !nvmStore.addr && nvmStore.data == $past(pwdata[15:0]))
    else $error("first label not sent to store");

  chk_label_refuse: assert property (
    setupPhase && pwrite && pwdata > 32'(pfi_pkg::LABEL_MAX) &&
    (addr12 == pfi_pkg::ADDR_LABEL1 || addr12 == pfi_pkg::ADDR_LABEL2)
    |=> pslverr)
    else $error("label value beyond 9999 accepted");

  chk_label_inert: assert property (
    accessPhase && pwrite && !panelMenuWrite &&
    (addr12 == pfi_pkg::ADDR_LABEL1 || addr12 == pfi_pkg::ADDR_LABEL2)
    |=> $stable(commSettings) && !presetDone)
    else $error("label write changed drive settings");

  chk_real_record: assert property (
    realFaultValid && !s_r.faultActive
    |=> faultAlarmOutput && histRecord.valid && histRecord.code == $past(realFaultCode) &&
        displayCode == $past(realFaultCode))
    else $error("real fault not recorded");

  chk_reset_clear: assert property (
    driveReset && !realFaultValid && !(accessPhase && pwrite && addr12 == pfi_pkg::ADDR_FAULT)
    |=> !faultAlarmOutput && retryEnable)
    else $error("drive reset did not clear the fault");

  chk_retry_restore: assert property (
    $fell(s_r.injected) |-> retryEnable)
    else $error("retry left off after injected fault");

  chk_preset_refuse: assert property (
    accessPhase && pwrite && pslverr && addr12 == pfi_pkg::ADDR_PRESET && !panelMenuWrite
    |=> !presetDone && $stable(commSettings))
    else $error("refused preset value acted");

  chk_preset_noop: assert property (
    accessPhase && pwrite && !pslverr && addr12 == pfi_pkg::ADDR_PRESET &&
    pwdata == 32'(pfi_pkg::NO_ACTION) && !panelMenuWrite
    |=> !presetDone && $stable(commSettings))
    else $error("preset no-action value acted");

  cov_inject: cover property (
    accessPhase && pwrite && addr12 == pfi_pkg::ADDR_FAULT ##1 s_r.injected);
  cov_late_fault: cover property (s_r.injected && realFaultValid);
  cov_restore: cover property (s_r.injected && driveReset);
  cov_preset: cover property (presetDone);

endmodule
`default_nettype wire

// [pkg/pfi_pkg.sv]
// Constants and types of the parameter bank for labels, fault injection and terminal preset.
// Overview of operation
// - Two user labels hold 0 to 9999, start at 9999, are kept in nonvolatile store.
// - User label contents never steer any drive behaviour; they are labels only.
// - Label writes are accepted while running, in any mode, whatever the write selection.
// - Labels, fault trigger and preset trigger are reachable only while display select is 0.
// - A valid injection code trips the drive and raises the fault alarm like a real fault.
// - Injection codes are only the listed fault data codes from 16 through 245.
// - The fault trigger always reads 9999, and writing 9999 causes no fault.
// - Values written to the fault trigger are never saved to nonvolatile store.
// - An injected fault shows as newest history; drive reset clears it and restores history.
// - A fault injection write is ignored while any fault is already active.
// - Automatic retry is disabled for a fault produced by injection.
// - A real fault after an injected one changes neither display nor history.
// - Writing 10 to the preset trigger loads all terminal communication settings.
// - Preset values: mode 0, speed 192, stop 10, parity 1, retries and check 9999, etc.
// - The preset trigger always reads 9999, and writing 9999 does nothing.
// - The preset overwrites every affected setting, changed by the user or not.
// - The panel menu triggers the same preset when 1 is written to its item.
package pfi_pkg;
  localparam logic [11:0] ADDR_LABEL1    = 12'h000;
  localparam logic [11:0] ADDR_LABEL2    = 12'h004;
  localparam logic [11:0] ADDR_FAULT     = 12'h008;
  localparam logic [11:0] ADDR_PRESET    = 12'h00C;
  localparam logic [11:0] ADDR_CTRL      = 12'h010;
  localparam logic [11:0] ADDR_STATUS    = 12'h014;
  localparam logic [11:0] ADDR_COMM_BASE = 12'h020;
  localparam logic [11:0] ADDR_COMM_LAST = 12'h044;
  localparam logic [15:0] LABEL_INIT        = 16'h270F;
  localparam logic [15:0] LABEL_MAX         = 16'h270F;
  localparam logic [15:0] NO_ACTION         = 16'h270F;
  localparam logic [15:0] PRESET_CODE       = 16'h000A;
  localparam logic [15:0] PANEL_PRESET_CODE = 16'h0001;
  localparam logic [15:0] EXT_SEL_INIT      = 16'h0000;
  localparam int STAT_ACTIVE_BIT = 0;
  localparam int STAT_INJ_BIT    = 1;
  localparam int STAT_RETRY_BIT  = 2;
  localparam int STAT_CODE_LSB   = 8;
  localparam int STAT_DISP_LSB   = 16;
  localparam int STAT_HIST_LSB   = 24;
  // Field order matters: the first field sits in the highest bits.
  typedef struct packed {
    logic [15:0] opMode;
    logic [15:0] speed;
    logic [15:0] stopBits;
    logic [15:0] parity;
    logic [15:0] retries;
    logic [15:0] checkIvl;
    logic [15:0] waitTime;
    logic [15:0] lineEnd;
    logic [15:0] startup;
    logic [15:0] protocol;
  } pfi_comm_t;
  localparam pfi_comm_t COMM_INIT = '{16'h0000, 16'h00C0, 16'h0001, 16'h0002, 16'h0001,
                                      16'h0000, 16'h270F, 16'h0001, 16'h0000, 16'h0000};
  localparam pfi_comm_t COMM_PRESET = '{16'h0000, 16'h00C0, 16'h000A, 16'h0001, 16'h270F,
                                        16'h270F, 16'h0000, 16'h0001, 16'h0001, 16'h0000};
  typedef struct packed {
    logic       valid;
    logic [7:0] code;
  } pfi_hist_t;
  typedef struct packed {
    logic        write;
    logic        addr;
    logic [15:0] data;
  } pfi_nvm_t;
  typedef struct packed {
    logic [15:0] label1;
    logic [15:0] label2;
    logic [15:0] extSel;
    logic        faultActive;
    logic        injected;
    logic        alarm;
    logic        retryEn;
    logic [7:0]  faultCode;
    logic [7:0]  histNewest;
    logic [7:0]  dispCode;
    pfi_comm_t   comm;
    logic        presetDone;
    pfi_hist_t   hist;
    pfi_nvm_t    nvm;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } pfi_state_t;
endpackage

// [verif/pfi_host_model.sv]
// Host model: an APB master that reads and writes the parameter bank.
`timescale 1ns/100ps
`default_nettype none
module pfi_host_model (
  input  wire logic        core_clk,
  output logic      [11:0] paddr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    paddr = 12'h000;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0000_0000;
  end
  // The request stands until pready is seen high at a rising edge, for at most 40 edges after penable.
  task automatic xfer(input logic [11:0] a, input logic wr, input logic [31:0] d,
                      output logic [31:0] rd, output logic err, output logic hung);
    int n;
    @(posedge core_clk);
    paddr <= a;
    pwrite <= wr;
    pwdata <= d;
    psel <= 1'b1;
    penable <= 1'b0;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    hung = (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // A released bus must not look like a repeat of the last word.
    pwdata <= ~d;
  endtask
endmodule
`default_nettype wire

// [verif/testbench.sv]
// Self-checking testbench of the parameter bank.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic                 core_clk = 1'b0;
  logic                 rst = 1'b1;
  logic [11:0]          paddr;
  logic                 psel, penable, pwrite, pready, pslverr;
  logic [31:0]          pwdata, prdata, rd;
  logic                 realFaultValid = 1'b0, driveReset = 1'b0, panelMenuWrite = 1'b0;
  logic [7:0]           realFaultCode = 8'h00;
  logic [15:0]          panelMenuData = 16'h0000;
  logic                 faultAlarmOutput, retryEnable, presetDone, err, hung;
  logic [7:0]           displayCode;
  pfi_pkg::pfi_hist_t   histRecord;
  pfi_pkg::pfi_nvm_t    nvmStore;
  pfi_pkg::pfi_comm_t   commSettings;
  int                   failures = 0, checkCount = 0, histCnt = 0, nvmCnt = 0, presetCnt = 0;
  logic [7:0] codes [28] = '{8'h10, 8'h11, 8'h12, 8'h20, 8'h21, 8'h22, 8'h30, 8'h31, 8'h40,
    8'h52, 8'h60, 8'h61, 8'h70, 8'h80, 8'h81, 8'h90, 8'h91, 8'hB0, 8'hB1, 8'hB2, 8'hC0,
    8'hC4, 8'hC5, 8'hC7, 8'hC9, 8'hD0, 8'hE6, 8'hF5};
  logic [7:0] bad [3] = '{8'h0F, 8'h13, 8'hF6};
  always #4 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (histRecord.valid === 1'b1) histCnt++;
    if (nvmStore.write === 1'b1) nvmCnt++;
    if (presetDone === 1'b1) presetCnt++;
  end
  pfi_host_model host (.core_clk(core_clk), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  pfi_param_bank dut (.core_clk(core_clk), .rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .realFaultValid(realFaultValid), .realFaultCode(realFaultCode),
    .driveReset(driveReset), .panelMenuWrite(panelMenuWrite), .panelMenuData(panelMenuData),
    .faultAlarmOutput(faultAlarmOutput), .retryEnable(retryEnable), .displayCode(displayCode),
    .histRecord(histRecord), .nvmStore(nvmStore), .commSettings(commSettings),
    .presetDone(presetDone));
  task automatic summarize;
    $display("comparisons %0d, mismatches %0d", checkCount, failures);
    if (failures == 0 && checkCount > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [159:0] got, input logic [159:0] exp, input string msg);
    checkCount++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t ns: %s", $time, msg);
    end
  endtask
  task automatic acc(input logic [11:0] a, input logic wr, input logic [31:0] d, input logic e);
    host.xfer(a, wr, d, rd, err, hung);
    if (hung) begin
      failures++;
      $display("wrong value at %0t ns: no pready", $time);
      summarize();
    end else begin
      chk(160'(err), 160'(e), "error response");
      @(posedge core_clk);
      #1;
    end
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    acc(a, 1'b0, 32'h0000_0000, 1'b0);
    chk(160'(rd), 160'(exp), "read data");
  endtask
  task automatic pulse(input int which, input logic [15:0] d);
    @(posedge core_clk);
    realFaultValid <= (which == 0);
    driveReset <= (which == 1);
    panelMenuWrite <= (which == 2);
    realFaultCode <= d[7:0];
    panelMenuData <= d;
    @(posedge core_clk);
    realFaultValid <= 1'b0;
    driveReset <= 1'b0;
    panelMenuWrite <= 1'b0;
    panelMenuData <= ~d;
    @(posedge core_clk);
    #1;
  endtask
  task automatic state(input logic alarm, input logic [7:0] code);
    chk(160'(faultAlarmOutput), 160'(alarm), "alarm output");
    chk(160'(retryEnable), 160'(1'b1), "retry enable");
    chk(160'(displayCode), 160'(code), "display code");
  endtask
  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    rdc(pfi_pkg::ADDR_LABEL1, 32'h0000_270F);
    rdc(pfi_pkg::ADDR_LABEL2, 32'h0000_270F);
    rdc(pfi_pkg::ADDR_FAULT, 32'h0000_270F);
    rdc(pfi_pkg::ADDR_PRESET, 32'h0000_270F);
    state(1'b0, 8'h00);
    acc(pfi_pkg::ADDR_LABEL1, 1'b1, 32'h0000_0000, 1'b0);
    acc(pfi_pkg::ADDR_LABEL2, 1'b1, 32'h0000_2710, 1'b1);
    rdc(pfi_pkg::ADDR_LABEL1, 32'h0000_0000);
    rdc(pfi_pkg::ADDR_LABEL2, 32'h0000_270F);
    chk(160'(nvmCnt), 160'(1), "label store");
    chk(commSettings, pfi_pkg::COMM_INIT, "labels steer nothing");
    acc(pfi_pkg::ADDR_CTRL, 1'b1, 32'h0000_0001, 1'b0);
    acc(pfi_pkg::ADDR_LABEL1, 1'b0, 32'h0000_0000, 1'b1);
    acc(pfi_pkg::ADDR_FAULT, 1'b1, 32'h0000_0010, 1'b1);
    acc(pfi_pkg::ADDR_PRESET, 1'b1, 32'h0000_000A, 1'b1);
    acc(pfi_pkg::ADDR_CTRL, 1'b1, 32'h0000_0000, 1'b0);
    acc(12'h018, 1'b0, 32'h0000_0000, 1'b1);
    state(1'b0, 8'h00);
    $display("test registers finished");
    acc(pfi_pkg::ADDR_FAULT, 1'b1, 32'h0000_270F, 1'b0);
    for (int i = 0; i < 3; i++) acc(pfi_pkg::ADDR_FAULT, 1'b1, 32'(bad[i]), 1'b1);
    state(1'b0, 8'h00);
    for (int i = 0; i < 28; i++) begin
      acc(pfi_pkg::ADDR_FAULT, 1'b1, 32'(codes[i]), 1'b0);
      chk(160'(faultAlarmOutput), 160'(1'b1), "injected trip");
      chk(160'(retryEnable), 160'(1'b0), "retry off");
      chk(160'(displayCode), 160'(codes[i]), "injected display");
      pulse(1, 16'h0000);
      state(1'b0, 8'h00);
    end
    chk(160'(histCnt + nvmCnt), 160'(1), "nothing recorded");
    pulse(0, 16'h0020);
    chk(160'(histCnt), 160'(1), "real fault recorded");
    chk(160'(histRecord.code), 160'(8'h20), "recorded code");
    acc(pfi_pkg::ADDR_LABEL1, 1'b1, 32'h0000_04D2, 1'b0);
    acc(pfi_pkg::ADDR_LABEL2, 1'b1, 32'h0000_1234, 1'b0);
    rdc(pfi_pkg::ADDR_LABEL1, 32'h0000_04D2);
    rdc(pfi_pkg::ADDR_LABEL2, 32'h0000_1234);
    chk(160'(nvmCnt), 160'(3), "labels stored while tripped");
    chk(160'(nvmStore.data), 160'(16'h1234), "stored label value");
    acc(pfi_pkg::ADDR_FAULT, 1'b1, 32'h0000_0010, 1'b0);
    state(1'b1, 8'h20);
    pulse(1, 16'h0000);
    acc(pfi_pkg::ADDR_FAULT, 1'b1, 32'h0000_00F5, 1'b0);
    pulse(0, 16'h0030);
    chk(160'(displayCode), 160'(8'hF5), "display held");
    chk(160'(histCnt), 160'(1), "later fault not recorded");
    pulse(1, 16'h0000);
    state(1'b0, 8'h20);
    $display("test faults finished");
    acc(pfi_pkg::ADDR_PRESET, 1'b1, 32'h0000_0005, 1'b1);
    acc(pfi_pkg::ADDR_PRESET, 1'b1, 32'h0000_270F, 1'b0);
    chk(commSettings, pfi_pkg::COMM_INIT, "no preset action");
    acc(pfi_pkg::ADDR_PRESET, 1'b1, 32'h0000_000A, 1'b0);
    chk(commSettings, pfi_pkg::COMM_PRESET, "preset values");
    chk(160'(presetCnt), 160'(1), "preset done");
    rdc(pfi_pkg::ADDR_COMM_BASE + 12'h004, 32'h0000_00C0);
    pulse(1, 16'h0000);
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    rdc(pfi_pkg::ADDR_LABEL1, 32'h0000_270F);
    pulse(2, 16'h0002);
    chk(commSettings, pfi_pkg::COMM_INIT, "panel other value");
    pulse(2, 16'h0001);
    chk(commSettings, pfi_pkg::COMM_PRESET, "panel preset");
    chk(160'(presetCnt), 160'(2), "panel preset done");
    $display("test preset finished");
    summarize();
  end
endmodule
`default_nettype wire
